/* File: rtl/picr_regs.vh */
// register offsets, field positions and reset values of the pin/irq config bank
// assumes word-wide register access at the listed offsets
`ifndef PICR_REGS_VH
`define PICR_REGS_VH
`define PICR_OFS_PIN_CTRL 8'h02
`define PICR_OFS_IRQ_MASK 8'h01
`define PICR_OFS_FIFO_THR 8'h06
`define PICR_OFS_REV_ID 8'h08
`define PICR_OFS_TADDR 8'h09
`define PICR_OFS_CLOCK_RATIO_RESULT 8'h0a
`define PICR_OFS_ALT_FN 8'h0b
`define PICR_OFS_CAL_CTRL 8'h50
`define PICR_BIT_POL 0
`define PICR_BIT_DRV 1
`define PICR_BIT_ENA 2
`define PICR_BIT_FIFO_MASK 8
`define PICR_BIT_CAL_EN 5
`define PICR_THR_LSB 8
`define PICR_THR_MSB 13
`define PICR_ALTB_LSB 8
`define PICR_ALTB_MSB 12
`define PICR_ALTA_LSB 0
`define PICR_ALTA_MSB 4
`define PICR_KEY_LSB 8
`define PICR_KEY_MSB 15
`define PICR_KEY_VALUE 8'had
`define PICR_TADDR_LSB 1
`define PICR_TADDR_MSB 7
`define PICR_TADDR_RST 7'h64
`define PICR_MASK_RST 16'h01e0
`define PICR_ALT_LEGACY 5'h00
`define PICR_ALT_IRQ 5'h01
`define PICR_ALT_SLOTS 5'h02
`define PICR_ALT_PA 5'h05
`define PICR_ALT_PB 5'h06
`define PICR_ALT_PAB 5'h07
`define PICR_ALT_DA 5'h0c
`define PICR_ALT_DB 5'h0d
`define PICR_ALT_DAB 5'h0e
`define PICR_ALT_TOG 5'h0f
`define PICR_ALT_ZERO 5'h10
`define PICR_ALT_ONE 5'h11
`define PICR_ALT_OSC 5'h13
`define PICR_PIN_CTRL_RST 3'h0
`define PICR_THR_RST 6'h00
`define PICR_ALT_RST 5'h00
`define PICR_CAL_EN_RST 1'h0
`define PICR_RATIO_RST 12'h000
`define PICR_CAL_CNT_RST 12'h000
`define PICR_CAL_CNT_START 12'h001
`define PICR_RDATA_RST 16'h0000
`endif

/* File: rtl/picr_top.v */
// pin, fifo-threshold interrupt and configuration register bank
// assumes a simple synchronous register port and slow-clock/timing events in the clk domain
// Notes on behaviour
// [RULE1] disabled pin a floats, status keeps updating
// [RULE2] drive style: always driven or open drain
// [RULE3] polarity bit selects active high or low
// [RULE4] fifo irq when count exceeds threshold
// [RULE5] fifo irq drops itself when count falls
// [RULE6] key byte must accompany target address write
// [RULE7] calibration counts fast cycles over two slow periods
// [RULE8] pin b code zero gives legacy data output
// [RULE9] pin b code one gives masked interrupt
// [RULE10] pin b code two spans first to last slot
// [RULE11] fifo mask bit one blocks the interrupt
// [RULE12] codes five to seven and twelve to fifteen select slot signals
// [RULE13] codes force zero, one, or slow oscillator
// [RULE14] compare re-evaluated after every push and pop
// [RULE15] unkeyed address write keeps previous address
`include "picr_regs.vh"
`default_nettype none
module picr_top #(
  parameter CNT_W = 7,
  parameter [7:0] REV_NUMBER = 8'h01,
  parameter [7:0] PART_IDENTITY = 8'h42
) (
  input wire clk,
  input wire reset,
  input wire ce,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata_ff,
  input wire [CNT_W-1:0] fifo_word_count,
  input wire slow_clk,
  input wire slot_a_pulse,
  input wire slot_b_pulse,
  input wire slot_a_data,
  input wire slot_b_data,
  input wire slot_a_active,
  input wire slot_b_active,
  input wire sample_done,
  input wire legacy_data,
  input wire other_irq,
  output reg pin_a_out_ff,
  output reg pin_a_oe_ff,
  output reg pin_b_out_ff,
  output reg pin_b_oe_ff,
  output reg fifo_irq_ff
);
  // REV_NUMBER and PART_IDENTITY defaults are arbitrary values
  localparam CAL_IDLE = 2'b00;
  localparam CAL_FIRST = 2'b01;
  localparam CAL_SECOND = 2'b10;
  localparam CAL_DONE = 2'b11;
  reg [2:0] pin_ctrl_ff;
  reg [15:0] mask_ff;
  reg [5:0] thr_ff;
  reg [6:0] taddr_ff;
  reg [11:0] ratio_ff;
  reg [4:0] alt_a_ff;
  reg [4:0] alt_b_ff;
  reg cal_en_ff;
  reg [11:0] cal_cnt_ff;
  reg [1:0] cal_state_ff;
  reg slow_d_ff;
  reg tog_ff;
  reg span_ff;
  wire fifo_hit;
  wire irq_gated;
  wire slow_rise;
  wire key_ok;
  wire pin_a_level;
  wire pin_b_level;
  wire wr_pin_ctrl;
  wire wr_mask;
  wire wr_thr;
  wire wr_taddr;
  wire wr_alt;
  wire wr_cal;
  wire rd_take;
  reg [15:0] nxt_rdata;

  function pin_fn;
    input [4:0] code;
    input irq;
    begin
      case (code)
        `PICR_ALT_LEGACY: pin_fn = legacy_data; // [RULE8]
        `PICR_ALT_IRQ: pin_fn = irq; // [RULE9]
        `PICR_ALT_SLOTS: pin_fn = span_ff; // [RULE10]
        `PICR_ALT_PA: pin_fn = slot_a_pulse; // [RULE12]
        `PICR_ALT_PB: pin_fn = slot_b_pulse; // [RULE12]
        `PICR_ALT_PAB: pin_fn = slot_a_pulse | slot_b_pulse; // [RULE12]
        `PICR_ALT_DA: pin_fn = slot_a_data; // [RULE12]
        `PICR_ALT_DB: pin_fn = slot_b_data; // [RULE12]
        `PICR_ALT_DAB: pin_fn = slot_a_data | slot_b_data; // [RULE12]
        `PICR_ALT_TOG: pin_fn = tog_ff; // [RULE12]
        `PICR_ALT_ZERO: pin_fn = 1'b0; // [RULE13]
        `PICR_ALT_ONE: pin_fn = 1'b1; // [RULE13]
        `PICR_ALT_OSC: pin_fn = slow_clk; // [RULE13]
        default: pin_fn = 1'b0; // unsupported codes read as low
      endcase
    end
  endfunction

  // one decoder for every write strobe; the read mux decodes reg_addr in its own case
  function addr_is;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      addr_is = (addr == ofs);
    end
  endfunction

  function [11:0] count_up;
    input [11:0] value;
    begin
      count_up = value + 12'h001;
    end
  endfunction

  // compared every cycle, so each push and pop is reflected next edge
  assign fifo_hit = ({{(8-CNT_W){1'b0}}, fifo_word_count} > {2'b00, thr_ff}); // [RULE4] [RULE14]
  assign irq_gated = (fifo_hit & ~mask_ff[`PICR_BIT_FIFO_MASK]) | other_irq; // [RULE11]
  assign slow_rise = slow_clk & ~slow_d_ff;
  assign key_ok = (reg_wdata[`PICR_KEY_MSB:`PICR_KEY_LSB] == `PICR_KEY_VALUE); // [RULE6]
  assign pin_a_level = pin_fn(alt_a_ff, irq_gated);
  assign pin_b_level = pin_fn(alt_b_ff, irq_gated);
  // ce is folded into every strobe, so a frozen block ignores the host entirely
  assign wr_pin_ctrl = ce & reg_wr & addr_is(reg_addr, `PICR_OFS_PIN_CTRL);
  assign wr_mask = ce & reg_wr & addr_is(reg_addr, `PICR_OFS_IRQ_MASK);
  assign wr_thr = ce & reg_wr & addr_is(reg_addr, `PICR_OFS_FIFO_THR);
  assign wr_taddr = ce & reg_wr & addr_is(reg_addr, `PICR_OFS_TADDR);
  assign wr_alt = ce & reg_wr & addr_is(reg_addr, `PICR_OFS_ALT_FN);
  assign wr_cal = ce & reg_wr & addr_is(reg_addr, `PICR_OFS_CAL_CTRL);
  assign rd_take = ce & reg_rd;

  always @* begin
    nxt_rdata = 16'h0000;
    case (reg_addr)
      `PICR_OFS_PIN_CTRL: nxt_rdata = {13'h0000, pin_ctrl_ff};
      `PICR_OFS_IRQ_MASK: nxt_rdata = mask_ff;
      `PICR_OFS_FIFO_THR: nxt_rdata = {2'b00, thr_ff, 8'h00};
      `PICR_OFS_REV_ID: nxt_rdata = {REV_NUMBER, PART_IDENTITY};
      `PICR_OFS_TADDR: nxt_rdata = {8'h00, taddr_ff, 1'b0};
      `PICR_OFS_CLOCK_RATIO_RESULT: nxt_rdata = {4'h0, ratio_ff};
      `PICR_OFS_ALT_FN: nxt_rdata = {3'b000, alt_b_ff, 3'b000, alt_a_ff};
      `PICR_OFS_CAL_CTRL: nxt_rdata = {10'h000, cal_en_ff, 5'h00};
      default: nxt_rdata = 16'h0000;
    endcase
  end

  // read data is held until the next read, so a slow host may fetch it late
  always @(posedge clk) begin
    if (reset) begin
      reg_rdata_ff <= `PICR_RDATA_RST;
    end else if (rd_take) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      pin_ctrl_ff <= `PICR_PIN_CTRL_RST;
    end else if (wr_pin_ctrl) begin
      pin_ctrl_ff <= reg_wdata[`PICR_BIT_ENA:`PICR_BIT_POL];
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      mask_ff <= `PICR_MASK_RST;
    end else if (wr_mask) begin
      mask_ff <= reg_wdata;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      thr_ff <= `PICR_THR_RST;
    end else if (wr_thr) begin
      thr_ff <= reg_wdata[`PICR_THR_MSB:`PICR_THR_LSB]; // [RULE4]
    end
  end

  // an unkeyed write leaves the address alone, so a stray write cannot move it
  always @(posedge clk) begin
    if (reset) begin
      taddr_ff <= `PICR_TADDR_RST;
    end else if (wr_taddr && key_ok) begin
      taddr_ff <= reg_wdata[`PICR_TADDR_MSB:`PICR_TADDR_LSB]; // [RULE6] [RULE15]
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      alt_b_ff <= `PICR_ALT_RST;
      alt_a_ff <= `PICR_ALT_RST;
    end else if (wr_alt) begin
      alt_b_ff <= reg_wdata[`PICR_ALTB_MSB:`PICR_ALTB_LSB];
      alt_a_ff <= reg_wdata[`PICR_ALTA_MSB:`PICR_ALTA_LSB];
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      cal_en_ff <= `PICR_CAL_EN_RST;
    end else if (wr_cal) begin
      cal_en_ff <= reg_wdata[`PICR_BIT_CAL_EN];
    end
  end

  // slow clock is taken as synchronous; one delay stage finds its rising edge
  always @(posedge clk) begin
    if (reset) begin
      slow_d_ff <= 1'b0;
    end else if (ce) begin
      slow_d_ff <= slow_clk;
    end
  end

  // calibration: start at a slow rising edge, stop two slow periods later
  always @(posedge clk) begin
    if (reset) begin
      cal_state_ff <= CAL_IDLE;
      cal_cnt_ff <= `PICR_CAL_CNT_RST;
      ratio_ff <= `PICR_RATIO_RST;
    end else if (ce) begin
      if (!cal_en_ff) begin
        cal_state_ff <= CAL_IDLE;
      end else begin
        case (cal_state_ff)
          CAL_IDLE: begin
            if (slow_rise) begin
              cal_state_ff <= CAL_FIRST;
              cal_cnt_ff <= `PICR_CAL_CNT_START;
            end
          end
          CAL_FIRST: begin
            if (slow_rise) begin
              cal_state_ff <= CAL_SECOND;
            end
            cal_cnt_ff <= count_up(cal_cnt_ff); // [RULE7]
          end
          CAL_SECOND: begin
            if (slow_rise) begin
              ratio_ff <= cal_cnt_ff; // [RULE7]
              cal_state_ff <= CAL_DONE;
            end else begin
              cal_cnt_ff <= count_up(cal_cnt_ff); // [RULE7]
            end
          end
          // one result per enable: clear and set the bit again to measure again
          CAL_DONE: cal_state_ff <= CAL_DONE;
          default: cal_state_ff <= CAL_IDLE;
        endcase
      end
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      tog_ff <= 1'b0;
      span_ff <= 1'b0;
    end else if (ce) begin
      if (sample_done) begin
        tog_ff <= ~tog_ff; // [RULE12]
      end
      // span follows the union of active slots: first start to last end
      span_ff <= slot_a_active | slot_b_active; // [RULE10]
    end
  end

  // level only, no sticky bit: the output drops as soon as the count falls
  always @(posedge clk) begin
    if (reset) begin
      fifo_irq_ff <= 1'b0;
    end else if (ce) begin
      fifo_irq_ff <= fifo_hit & ~mask_ff[`PICR_BIT_FIFO_MASK]; // [RULE5] [RULE11]
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      pin_a_out_ff <= 1'b0;
      pin_a_oe_ff <= 1'b0;
    end else if (ce) begin
      pin_a_out_ff <= pin_a_level ^ pin_ctrl_ff[`PICR_BIT_POL]; // [RULE3]
      // open drain drives only while asserted; disable floats regardless
      pin_a_oe_ff <= pin_ctrl_ff[`PICR_BIT_ENA] &
        (~pin_ctrl_ff[`PICR_BIT_DRV] | pin_a_level); // [RULE1] [RULE2]
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      pin_b_out_ff <= 1'b0;
      pin_b_oe_ff <= 1'b0;
    end else if (ce) begin
      // pin b has no enable, drive or polarity control of its own
      pin_b_out_ff <= pin_b_level;
      pin_b_oe_ff <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: verification/picr_checker_asserts.sv */
// checker: timing relations on the pin and fifo irq outputs of the bank
// assumes shadow copies of host writes track the bank's own fields
`default_nettype none
module picr_checker #(parameter CNT_W = 7) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [CNT_W-1:0] fifo_word_count,
  input wire logic slot_a_pulse,
  input wire logic legacy_data,
  input wire logic pin_a_oe_ff,
  input wire logic pin_b_out_ff,
  input wire logic fifo_irq_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] thr_ff;
  logic [4:0] altb_ff;
  logic msk_ff, ena_ff, drv_ff, wr_ok;
  assign wr_ok = ce & reg_wr;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // shadows only: the bodies are hidden, so config is rebuilt from writes
  always @(posedge clk) begin
    if (reset) {thr_ff, altb_ff, msk_ff, ena_ff, drv_ff} <= 14'h04;
    else if (wr_ok && reg_addr == 8'h01) msk_ff <= reg_wdata[8];
    else if (wr_ok && reg_addr == 8'h02) {ena_ff, drv_ff} <= reg_wdata[2:1];
    else if (wr_ok && reg_addr == 8'h06) thr_ff <= reg_wdata[13:8];
    else if (wr_ok && reg_addr == 8'h0b) altb_ff <= reg_wdata[12:8];
  end
  property p_irq_level; ce |=> fifo_irq_ff == $past(fifo_word_count > thr_ff && !msk_ff); endproperty
  a_irq_level: assert property (p_irq_level) else $error("fifo irq level wrong");
  property p_irq_fall; ce && fifo_word_count <= thr_ff |=> !fifo_irq_ff; endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("fifo irq not dropped");
  property p_mask; ce && msk_ff |=> !fifo_irq_ff; endproperty
  a_mask: assert property (p_mask) else $error("masked irq passed");
  property p_pa_float; ce && !ena_ff |=> !pin_a_oe_ff; endproperty
  a_pa_float: assert property (p_pa_float) else $error("disabled pin a driven");
  property p_pa_drive; ce && ena_ff && !drv_ff |=> pin_a_oe_ff; endproperty
  a_pa_drive: assert property (p_pa_drive) else $error("pin a not driven");
  property p_pb_legacy; ce && altb_ff == 5'h00 |=> pin_b_out_ff == $past(legacy_data); endproperty
  a_pb_legacy: assert property (p_pb_legacy) else $error("pin b legacy wrong");
  property p_pb_slot; ce && altb_ff == 5'h05 |=> pin_b_out_ff == $past(slot_a_pulse); endproperty
  a_pb_slot: assert property (p_pb_slot) else $error("pin b slot pulse wrong");
  property p_pb_force; ce && altb_ff[4:1] == 4'h8 |=> pin_b_out_ff == $past(altb_ff[0]); endproperty
  a_pb_force: assert property (p_pb_force) else $error("pin b forced level wrong");
endmodule
bind picr_top picr_checker #(.CNT_W(CNT_W)) picr_checker_inst (.clk(clk), .reset(reset),
  .ce(ce), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .fifo_word_count(fifo_word_count), .slot_a_pulse(slot_a_pulse), .legacy_data(legacy_data),
  .pin_a_oe_ff(pin_a_oe_ff), .pin_b_out_ff(pin_b_out_ff), .fifo_irq_ff(fifo_irq_ff));
`default_nettype wire

/* File: verification/picr_host_model.sv */
// host model: one register read or write per call
// assumes requests are sampled on the rising edge
`default_nettype none
module picr_host_model (
  input wire logic clk,
  input wire logic [15:0] reg_rdata_ff,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 26'h0;
  // idle data is inverted so a stale word never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    @(negedge clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clk);
    {reg_wr, reg_rd, reg_wdata} = {2'b00, ~d};
    @(negedge clk);
    q = reg_rdata_ff;
  endtask
endmodule
`default_nettype wire

/* File: verification/picr_top_tb_top.sv */
// bench: register traffic, fifo level sweep and pin checks on the bank
// assumes picr_top, picr_host_model and the bound checker
`default_nettype none
module picr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] rev_id = 16'h035c; // arbitrary identity value
  logic clk = 0, reset = 1, ce = 1, irq, pa_out, pa_oe, pb_out, pb_oe, wr_s, rd_s;
  logic pb_want, pb_prev;
  logic [6:0] cnt = 0;
  logic [7:0] addr;
  logic [15:0] cyc = 0, q, wdata, rdata, c0;
  logic [4:0] codes [12] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h06, 5'h07, 5'h0c, 5'h0d,
    5'h0e, 5'h10, 5'h11, 5'h13};
  int mismatches = 0, tests_run = 0, i, j;
  picr_top #(.REV_NUMBER(rev_id[15:8]), .PART_IDENTITY(rev_id[7:0])) picr_top_inst (
    .clk(clk), .reset(reset), .ce(ce), .reg_wr(wr_s), .reg_rd(rd_s), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata_ff(rdata), .fifo_word_count(cnt), .slow_clk(cyc[9]),
    .slot_a_pulse(cyc[2]), .slot_b_pulse(cyc[3]), .slot_a_data(cyc[4]), .slot_b_data(cyc[5]),
    .slot_a_active(cyc[6]), .slot_b_active(cyc[7]), .sample_done(cyc[0]),
    .legacy_data(cyc[1]), .other_irq(1'b0), .pin_a_out_ff(pa_out), .pin_a_oe_ff(pa_oe),
    .pin_b_out_ff(pb_out), .pin_b_oe_ff(pb_oe), .fifo_irq_ff(irq));
  picr_host_model picr_host_model_inst (.clk(clk), .reg_rdata_ff(rdata), .reg_wr(wr_s),
    .reg_rd(rd_s), .reg_addr(addr), .reg_wdata(wdata));
  initial forever #12.5 clk = ~clk;
  task automatic complete_run();
    if (mismatches == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // timing-core inputs follow a free counter; ceiling well above the run
  always @(negedge clk) begin
    cyc <= cyc + 16'h1;
    if (cyc == 16'h4e20) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    picr_host_model_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    picr_host_model_inst.xfer(1'b0, a, 16'h0, q);
    check(q, e);
  endtask
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  // pin b level expected one cycle after the inputs c; span lags one cycle more
  function automatic logic pb_exp(input logic [4:0] code, input logic [15:0] c);
    logic [15:0] p;
    p = c - 16'h1;
    case (code)
      5'h00: pb_exp = c[1];
      5'h02: pb_exp = p[6] | p[7];
      5'h05: pb_exp = c[2];
      5'h06: pb_exp = c[3];
      5'h07: pb_exp = c[2] | c[3];
      5'h0c: pb_exp = c[4];
      5'h0d: pb_exp = c[5];
      5'h0e: pb_exp = c[4] | c[5];
      5'h11: pb_exp = 1'b1;
      5'h13: pb_exp = c[9];
      default: pb_exp = 1'b0;
    endcase
  endfunction
  initial begin
    repeat (10) @(negedge clk);
    reset = 0;
    rc(8'h06, 16'h0000);
    rc(8'h01, 16'h01e0);
    rc(8'h0a, 16'h0000);
    rc(8'h08, rev_id);
    rc(8'h3c, 16'h0000);
    wr(8'h09, 16'h0012);
    rc(8'h09, 16'h00c8);
    wr(8'h09, 16'had23);
    rc(8'h09, 16'h0022);
    wr(8'h01, 16'h0000);
    wr(8'h06, 16'h0500);
    for (i = 0; i < 10; i++) begin
      cnt = (i < 5) ? 7'(i + 3) : 7'(12 - i);
      w(3);
      check({15'h0, irq}, {15'h0, cnt > 7'd5});
    end
    wr(8'h06, 16'h3f00);
    cnt = 7'h40;
    w(3);
    check({15'h0, irq}, 16'h1);
    wr(8'h0b, 16'h0001);
    for (i = 0; i < 2; i++) begin
      wr(8'h02, 16'h0004 | 16'(i));
      w(3);
      check({14'h0, pa_oe, pa_out}, {14'h0, 1'b1, i == 0});
    end
    wr(8'h02, 16'h0006);
    cnt = 7'h3f;
    w(3);
    check({15'h0, irq}, 16'h0);
    check({15'h0, pa_oe}, 16'h0);
    wr(8'h02, 16'h0000);
    cnt = 7'h40;
    w(3);
    check({15'h0, pa_oe}, 16'h0);
    wr(8'h01, 16'h0100);
    w(3);
    check({15'h0, irq}, 16'h0);
    ce = 0;
    wr(8'h06, 16'h0100);
    ce = 1;
    rc(8'h06, 16'h3f00);
    for (i = 0; i < 12; i++) begin
      wr(8'h0b, {3'h0, codes[i], 8'h00});
      w(3);
      for (j = 0; j < 3; j++) begin
        w(1);
        pb_want = pb_exp(codes[i], cyc);
        check({15'h0, pb_out}, {15'h0, pb_want});
      end
      check({15'h0, pb_oe}, 16'h1);
    end
    wr(8'h0b, 16'h0f00);
    w(3);
    for (i = 0; i < 2; i++) begin
      c0 = cyc;
      pb_prev = pb_out;
      w(1);
      check({15'h0, pb_out ^ pb_prev}, {15'h0, c0[0]});
    end
    wr(8'h50, 16'h0020);
    w(4200);
    picr_host_model_inst.xfer(1'b0, 8'h0a, 16'h0, q);
    check({15'h0, q inside {[16'h07ff:16'h0801]}}, 16'h1);
    complete_run();
  end
endmodule
`default_nettype wire
